// >>> inc/dse_pkg.sv
// Purpose: Shared constants, types and helpers for the data, strobe and error link.
// Assumes: One 10 MHz clock on both ends; link clock made by the controller.
// Notes: Times are in ns; cycle counts derive from them.
package dse_pkg;
  localparam int CLK_NS = 100;
  localparam int CK_PERIOD_NS = 800;
  localparam int CK_HALF_CYC = CK_PERIOD_NS / (2 * CLK_NS);
  localparam int BEAT_CYC = 4;
  localparam int STROBE_PH = 2;
  localparam int BURST_LEN = 8;
  localparam int CRC_ALERT_NS = 1000;
  localparam int CRC_ALERT_CYC = CRC_ALERT_NS / CLK_NS;
  localparam int PAR_ALERT_NS = 8000;
  localparam int PAR_ALERT_CYC = PAR_ALERT_NS / CLK_NS;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;
  ////////////////////////////////////////////////////////////////////////////
  // Controller register map.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_RDATA0 = 8'h20;
  localparam int RDATA_WORDS = 4;
  localparam int CTRL_W = 9;
  localparam int CTRL_VREF = 2;
  localparam int CTRL_TDQS = 3;
  localparam int CTRL_ODT = 6;
  localparam int CTRL_TEN = 7;
  localparam int CTRL_PINJ = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam int CMD_W = 21;
  localparam int CMD_BA_LSB = 15;
  localparam int CMD_BG_LSB = 17;
  localparam int CMD_WRITE = 20;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ALERT = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ALERT = 1;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic dbi_en;
    logic dm_en;
    logic tdqs_en;
    logic vref_mon;
    logic par_en;
    logic crc_en;
  } dse_mode_t;
  typedef struct packed {
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [14:0] addr;
  } dse_cmd_t;
  function automatic logic dse_parity(input dse_cmd_t c);
    return ^c;
  endfunction : dse_parity
  function automatic logic [7:0] dse_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : dse_crc8
endpackage : dse_pkg

// >>> inc/dse_link_if.sv
// Purpose: Pin bundle between controller and memory device.
// Assumes: Each two-way pin is driven by at most one end at a time.
// Notes: Undriven pins settle at their idle level.
`timescale 1ns/1ps
interface dse_link_if;
  logic ck;
  logic cs_n;
  dse_pkg::dse_cmd_t cmd;
  logic par;
  logic ten;
  logic odt;
  dse_pkg::dse_mode_t mode;
  logic [15:0] dq_c_o, dq_c_oe, dq_d_o, dq_d_oe, dq;
  logic [1:0] dqst_c_o, dqsc_c_o, dqs_c_oe, dqst_d_o, dqsc_d_o, dqs_d_oe, dqs_t, dqs_c;
  logic [1:0] dm_c_o, dm_c_oe, dm_d_o, dm_d_oe, dm;
  logic alert_c_o, alert_c_oe, alert_d_o, alert_d_oe, alert;
  // Data, mask and alert idle high; the true strobe idles low, its complement high.
  assign dq = (dq_c_oe & dq_c_o) | (~dq_c_oe & dq_d_oe & dq_d_o) | (~dq_c_oe & ~dq_d_oe);
  assign dqs_t = (dqs_c_oe & dqst_c_o) | (~dqs_c_oe & dqs_d_oe & dqst_d_o);
  assign dqs_c = (dqs_c_oe & dqsc_c_o) | (~dqs_c_oe & dqs_d_oe & dqsc_d_o) |
                 (~dqs_c_oe & ~dqs_d_oe);
  assign dm = (dm_c_oe & dm_c_o) | (~dm_c_oe & dm_d_oe & dm_d_o) | (~dm_c_oe & ~dm_d_oe);
  assign alert = (alert_c_oe & alert_c_o) | (~alert_c_oe & alert_d_oe & alert_d_o) |
                 (~alert_c_oe & ~alert_d_oe);
  modport ctl (output ck, cs_n, cmd, par, ten, odt, mode, dq_c_o, dq_c_oe, dqst_c_o, dqsc_c_o,
               dqs_c_oe, dm_c_o, dm_c_oe, alert_c_o, alert_c_oe,
               input dq, dqs_t, dqs_c, dm, alert);
  modport dev (input ck, cs_n, cmd, par, ten, odt, mode, dq, dqs_t, dqs_c, dm, alert,
               output dq_d_o, dq_d_oe, dqst_d_o, dqsc_d_o, dqs_d_oe, dm_d_o, dm_d_oe,
               alert_d_o, alert_d_oe);
endinterface : dse_link_if

// >>> logic/dse_device.sv
// Purpose: Memory device end of the data, strobe and error link.
// Assumes: Link pins are asynchronous to pclk and pass two flip-flops first.
// Notes: Holds one burst of eight 16-bit beats.
`timescale 1ns/1ps
// How it works
// [RL1] Write CRC byte follows last data beat.
// [RL2] Vref monitor drives internal level on DQ0.
// [RL3] Controller disables termination during Vref monitor.
// [RL4] Device strobes reads; controller centres write strobes.
// [RL5] Lower strobe times low byte, upper high.
// [RL6] Strobes count only as true differential pairs.
// [RL7] Controller keeps termination strobe off on x16.
// [RL8] Enabled termination strobe mirrors strobe termination.
// [RL9] Disabled termination strobe pin is mask/inversion.
// [RL10] Even parity checked over command, bank, address.
// [RL11] Parity valid with command while select low.
// [RL12] CRC error pulses alert low, then releases.
// [RL13] Parity error holds alert low much longer.
// [RL14] Connectivity test turns alert into an input.
// [RL15] Test enable high enters connectivity test mode.
// [RL16] Masked write beats are discarded.
// [RL17] Inversion low means data is inverted.
// [RL18] Alert stays high without an error event.
module dse_device (
  input wire logic pclk,
  input wire logic presetn,
  dse_link_if.dev link,
  input wire logic vref_level,
  output logic crc_err,
  output logic par_err,
  output logic ten_active,
  output logic alert_in,
  output logic tdqs_term,
  output logic [15:0] first_word
);
  typedef enum logic [1:0] {D_IDLE, D_WR, D_RD} dse_dev_state_t;
  typedef struct packed {
    dse_dev_state_t state;
    logic [1:0] ck_s;
    logic ck_d;
    dse_pkg::dse_cmd_t cmd_s1;
    dse_pkg::dse_cmd_t cmd_s2;
    logic [1:0] cs_s;
    logic [1:0] par_s;
    logic [1:0] ten_s;
    logic [1:0] odt_s;
    logic [1:0] alert_s;
    dse_pkg::dse_mode_t mode_s1;
    dse_pkg::dse_mode_t mode_s2;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic [1:0] dqst_s1;
    logic [1:0] dqst_s2;
    logic [1:0] dqsc_s1;
    logic [1:0] dqsc_s2;
    logic [1:0] dm_s1;
    logic [1:0] dm_s2;
    logic [1:0] dqs_d;
    logic [1:0][3:0] beat;
    logic [1:0][7:0] crc;
    logic [1:0] lane_done;
    logic crc_bad;
    logic [7:0][15:0] mem;
    logic [7:0] alert_cnt;
    logic [3:0] rd_beat;
    logic [2:0] rd_tmr;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
    logic [1:0] dqst_o;
    logic [1:0] dqsc_o;
    logic [1:0] dqs_oe;
    logic [1:0] dm_oe;
    logic alert_o;
    logic alert_oe;
    logic crc_err;
    logic par_err;
    logic ten_active;
    logic alert_in;
    logic tdqs_term;
  } dse_dev_st_t;

  dse_dev_st_t r;
  dse_dev_st_t next_r;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic ck_rise;
    logic cmd_ok;
    logic par_bad;
    logic [7:0] byte_v;
    logic tog;
    logic pin_fn;
    next_r = r;
    ck_rise = 1'b0;
    cmd_ok = 1'b0;
    par_bad = 1'b0;
    byte_v = 8'h00;
    tog = 1'b0;
    pin_fn = 1'b0;
    next_r.ck_s = {r.ck_s[0], link.ck};
    next_r.ck_d = r.ck_s[1];
    next_r.cmd_s1 = link.cmd;
    next_r.cmd_s2 = r.cmd_s1;
    next_r.cs_s = {r.cs_s[0], link.cs_n};
    next_r.par_s = {r.par_s[0], link.par};
    next_r.ten_s = {r.ten_s[0], link.ten};
    next_r.odt_s = {r.odt_s[0], link.odt};
    next_r.alert_s = {r.alert_s[0], link.alert};
    next_r.mode_s1 = link.mode;
    next_r.mode_s2 = r.mode_s1;
    next_r.dq_s1 = link.dq;
    next_r.dq_s2 = r.dq_s1;
    next_r.dqst_s1 = link.dqs_t;
    next_r.dqst_s2 = r.dqst_s1;
    next_r.dqsc_s1 = link.dqs_c;
    next_r.dqsc_s2 = r.dqsc_s1;
    next_r.dm_s1 = link.dm;
    next_r.dm_s2 = r.dm_s1;
    next_r.dqs_d = r.dqst_s2;
    next_r.crc_err = 1'b0;
    next_r.par_err = 1'b0;
    ck_rise = r.ck_s[1] & ~r.ck_d;
    cmd_ok = ck_rise & ~r.cs_s[1] & ~r.ten_s[1]; // RL15
    par_bad = cmd_ok & r.mode_s2.par_en &
              (dse_pkg::dse_parity(r.cmd_s2) != r.par_s[1]); // RL10
    if (r.alert_cnt != 8'h00) begin
      next_r.alert_cnt = r.alert_cnt - 8'h01;
    end
    if (par_bad) begin
      next_r.par_err = 1'b1;
      next_r.alert_cnt = 8'(dse_pkg::PAR_ALERT_CYC); // RL13
    end
    unique case (r.state)
      D_IDLE: begin
        next_r.dq_oe = {15'h0000, r.mode_s2.vref_mon}; // RL2
        next_r.dq_o = {15'h0000, vref_level}; // RL2
        if (cmd_ok && !par_bad && r.cmd_s2.act_n && r.cmd_s2.ras_n && !r.cmd_s2.cas_n) begin
          if (!r.cmd_s2.we_n) begin
            next_r.state = D_WR;
            next_r.beat = '0;
            next_r.crc = {2{dse_pkg::CRC_INIT}};
            next_r.lane_done = 2'b00;
            next_r.crc_bad = 1'b0;
          end else begin
            next_r.state = D_RD;
            next_r.rd_beat = 4'h0;
            next_r.rd_tmr = 3'h0;
            next_r.dq_oe = 16'hffff;
            next_r.dqs_oe = 2'b11;
            next_r.dqst_o = 2'b00;
            next_r.dqsc_o = 2'b11;
            next_r.dm_oe = r.mode_s2.dbi_en ? 2'b11 : 2'b00;
          end
        end
      end
      D_WR: begin
        for (int l = 0; l < 2; l++) begin
          tog = (r.dqst_s2[l] ^ r.dqs_d[l]) & (r.dqst_s2[l] ^ r.dqsc_s2[l]); // RL5 RL6
          pin_fn = ~(r.mode_s2.tdqs_en && l == 0); // RL8 RL9
          byte_v = r.dq_s2[8*l +: 8];
          if (tog && !r.lane_done[l]) begin
            if (r.beat[l] < 4'(dse_pkg::BURST_LEN)) begin
              if (pin_fn && r.mode_s2.dbi_en && !r.dm_s2[l]) begin
                byte_v = ~byte_v; // RL17
              end
              if (!(pin_fn && r.mode_s2.dm_en && !r.dm_s2[l])) begin
                next_r.mem[r.beat[l][2:0]][8*l +: 8] = byte_v; // RL16
              end
              next_r.crc[l] = dse_pkg::dse_crc8(r.crc[l], byte_v);
              next_r.beat[l] = r.beat[l] + 4'h1;
              if (r.beat[l] == 4'(dse_pkg::BURST_LEN - 1) && !r.mode_s2.crc_en) begin
                next_r.lane_done[l] = 1'b1;
              end
            end else begin
              if (byte_v != r.crc[l]) begin
                next_r.crc_bad = 1'b1; // RL1
              end
              next_r.lane_done[l] = 1'b1;
            end
          end
        end
        if (&r.lane_done) begin
          next_r.state = D_IDLE;
          if (r.crc_bad) begin
            next_r.crc_err = 1'b1;
            if (next_r.alert_cnt < 8'(dse_pkg::CRC_ALERT_CYC)) begin
              next_r.alert_cnt = 8'(dse_pkg::CRC_ALERT_CYC); // RL12
            end
          end
        end
      end
      D_RD: begin
        next_r.rd_tmr = r.rd_tmr + 3'h1;
        if (r.rd_tmr == 3'(dse_pkg::BEAT_CYC - 1)) begin
          next_r.rd_tmr = 3'h0;
          if (r.rd_beat < 4'(dse_pkg::BURST_LEN)) begin
            next_r.dq_o = r.mem[r.rd_beat[2:0]];
            next_r.dqst_o = ~r.dqst_o; // RL4
            next_r.dqsc_o = ~r.dqsc_o; // RL6
            next_r.rd_beat = r.rd_beat + 4'h1;
          end else begin
            next_r.state = D_IDLE;
            next_r.dq_oe = 16'h0000;
            next_r.dqs_oe = 2'b00;
            next_r.dm_oe = 2'b00;
          end
        end
      end
      default: begin
        next_r.state = D_IDLE;
      end
    endcase
    next_r.alert_oe = ~r.ten_s[1]; // RL14
    next_r.alert_o = (next_r.alert_cnt == 8'h00); // RL18
    next_r.ten_active = r.ten_s[1];
    next_r.alert_in = r.ten_s[1] ? r.alert_s[1] : 1'b1; // RL14
    next_r.tdqs_term = r.mode_s2.tdqs_en & r.odt_s[1]; // RL8
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.cmd_s1 <= '1;
      r.cmd_s2 <= '1;
      r.cs_s <= 2'b11;
      r.dqsc_s1 <= 2'b11;
      r.dqsc_s2 <= 2'b11;
      r.dm_s1 <= 2'b11;
      r.dm_s2 <= 2'b11;
      r.alert_s <= 2'b11;
      r.dqsc_o <= 2'b11;
      r.alert_o <= 1'b1;
      r.alert_in <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin and user outputs.
  assign link.dq_d_o = r.dq_o;
  assign link.dq_d_oe = r.dq_oe;
  assign link.dqst_d_o = r.dqst_o;
  assign link.dqsc_d_o = r.dqsc_o;
  assign link.dqs_d_oe = r.dqs_oe;
  assign link.dm_d_o = 2'b11;
  assign link.dm_d_oe = r.dm_oe;
  assign link.alert_d_o = r.alert_o;
  assign link.alert_d_oe = r.alert_oe;
  assign crc_err = r.crc_err;
  assign par_err = r.par_err;
  assign ten_active = r.ten_active;
  assign alert_in = r.alert_in;
  assign tdqs_term = r.tdqs_term;
  assign first_word = r.mem[0];
endmodule : dse_device

// >>> logic/dse_ctrl.sv
// Purpose: Controller end of the link, run by software over APB.
// Assumes: Link clock made here by a divider; device pins synchronised.
// Notes: One burst at a time; a burst is started by writing the command word.
`timescale 1ns/1ps
module dse_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  dse_link_if.ctl link
);
  typedef enum logic [1:0] {C_IDLE, C_CMD, C_WR, C_RD} dse_ctl_state_t;
  typedef struct packed {
    dse_ctl_state_t state;
    logic [dse_pkg::CTRL_W-1:0] ctrl;
    logic [dse_pkg::CMD_W-1:0] cmdr;
    logic [15:0] wdata;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0][15:0] rdat;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic [2:0] div;
    logic ck;
    logic issued;
    logic [3:0] beat;
    logic [2:0] ph;
    logic [1:0][3:0] rbeat;
    logic [1:0][7:0] crc;
    logic cs_n;
    dse_pkg::dse_cmd_t cmd;
    logic par;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
    logic [1:0] dqst;
    logic [1:0] dqsc;
    logic [1:0] dqs_oe;
    logic [1:0] dm_o;
    logic [1:0] dm_oe;
    logic [1:0] alert_s;
    logic alert_d;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic [1:0] dqst_s1;
    logic [1:0] dqst_s2;
    logic [1:0] dqsc_s1;
    logic [1:0] dqsc_s2;
    logic [1:0] dm_s1;
    logic [1:0] dm_s2;
    logic [1:0] dqs_d;
  } dse_ctl_st_t;

  dse_ctl_st_t r;
  dse_ctl_st_t next_r;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    dse_pkg::dse_mode_t m;
    logic ck_fall;
    logic [3:0] nbeats;
    logic [15:0] word;
    logic [7:0] byte_v;
    logic done_ev;
    logic alert_ev;
    next_r = r;
    m = dse_pkg::dse_mode_t'(r.ctrl[5:0]);
    ck_fall = 1'b0;
    nbeats = m.crc_en ? 4'(dse_pkg::BURST_LEN + 1) : 4'(dse_pkg::BURST_LEN);
    word = 16'h0000;
    byte_v = 8'h00;
    done_ev = 1'b0;
    alert_ev = 1'b0;
    next_r.alert_s = {r.alert_s[0], link.alert};
    next_r.alert_d = r.alert_s[1];
    next_r.dq_s1 = link.dq;
    next_r.dq_s2 = r.dq_s1;
    next_r.dqst_s1 = link.dqs_t;
    next_r.dqst_s2 = r.dqst_s1;
    next_r.dqsc_s1 = link.dqs_c;
    next_r.dqsc_s2 = r.dqsc_s1;
    next_r.dm_s1 = link.dm;
    next_r.dm_s2 = r.dm_s1;
    next_r.dqs_d = r.dqst_s2;
    alert_ev = r.alert_d & ~r.alert_s[1];
    next_r.div = r.div + 3'h1;
    if (r.div == 3'(dse_pkg::CK_HALF_CYC - 1)) begin
      next_r.div = 3'h0;
      next_r.ck = ~r.ck;
      ck_fall = r.ck;
    end
    unique case (r.state)
      C_IDLE: begin
      end
      C_CMD: begin
        if (ck_fall && !r.issued) begin
          next_r.issued = 1'b1;
          next_r.cs_n = 1'b0;
          next_r.cmd = '{act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b0, we_n: ~r.cmdr[dse_pkg::CMD_WRITE],
                         bg: r.cmdr[dse_pkg::CMD_BG_LSB +: 2], ba: r.cmdr[dse_pkg::CMD_BA_LSB +: 2],
                         addr: r.cmdr[14:0]};
          next_r.par = dse_pkg::dse_parity(next_r.cmd) ^ r.ctrl[dse_pkg::CTRL_PINJ]; // RL11
        end else if (ck_fall) begin
          next_r.cs_n = 1'b1;
          next_r.beat = 4'h0;
          next_r.ph = 3'h0;
          next_r.rbeat = '0;
          next_r.crc = {2{dse_pkg::CRC_INIT}};
          next_r.dqst = 2'b00;
          next_r.dqsc = 2'b11;
          next_r.state = r.cmdr[dse_pkg::CMD_WRITE] ? C_WR : C_RD;
        end
      end
      C_WR: begin
        next_r.ph = (r.ph == 3'(dse_pkg::BEAT_CYC - 1)) ? 3'h0 : r.ph + 3'h1;
        if (r.ph == 3'h0 && r.beat == nbeats) begin
          next_r.dq_oe = 16'h0000;
          next_r.dqs_oe = 2'b00;
          next_r.dm_oe = 2'b00;
          next_r.state = C_IDLE;
          done_ev = 1'b1;
        end else if (r.ph == 3'h0) begin
          word = r.wdata + {12'h000, r.beat};
          next_r.dq_oe = 16'hffff;
          next_r.dqs_oe = 2'b11;
          next_r.dm_oe = 2'b11;
          for (int l = 0; l < 2; l++) begin
            byte_v = (r.beat == 4'(dse_pkg::BURST_LEN)) ?
                     r.crc[l] ^ {7'h00, r.ctrl[dse_pkg::CTRL_PINJ]} : word[8*l +: 8]; // RL1
            next_r.dm_o[l] = 1'b1;
            if (m.dbi_en && r.beat < 4'(dse_pkg::BURST_LEN) && $countones(byte_v) > 4) begin
              byte_v = ~byte_v; // RL17
              next_r.dm_o[l] = 1'b0;
            end
            next_r.dq_o[8*l +: 8] = byte_v;
          end
        end else if (r.ph == 3'(dse_pkg::STROBE_PH)) begin
          next_r.dqst = ~r.dqst; // RL4
          next_r.dqsc = ~r.dqsc; // RL6
          next_r.beat = r.beat + 4'h1;
          word = r.wdata + {12'h000, r.beat};
          for (int l = 0; l < 2; l++) begin
            next_r.crc[l] = dse_pkg::dse_crc8(r.crc[l], word[8*l +: 8]);
          end
        end
      end
      C_RD: begin
        for (int l = 0; l < 2; l++) begin
          byte_v = r.dq_s2[8*l +: 8];
          if (m.dbi_en && !r.dm_s2[l]) begin
            byte_v = ~byte_v; // RL17
          end
          if ((r.dqst_s2[l] ^ r.dqs_d[l]) && (r.dqst_s2[l] ^ r.dqsc_s2[l]) &&
              r.rbeat[l] < 4'(dse_pkg::BURST_LEN)) begin
            next_r.rdat[r.rbeat[l][2:0]][8*l +: 8] = byte_v; // RL5
            next_r.rbeat[l] = r.rbeat[l] + 4'h1;
          end
        end
        if ((r.rbeat[0] == 4'(dse_pkg::BURST_LEN) && r.rbeat[1] == 4'(dse_pkg::BURST_LEN)) ||
            alert_ev) begin
          next_r.state = C_IDLE;
          done_ev = 1'b1;
        end
      end
    endcase
    next_r.pready = 1'b0;
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h0000_0000;
      if (pwrite) begin
        unique case (paddr)
          dse_pkg::REG_CTRL: begin
            next_r.ctrl = pwdata[dse_pkg::CTRL_W-1:0];
            next_r.ctrl[dse_pkg::CTRL_TDQS] = 1'b0; // RL7
            if (pwdata[dse_pkg::CTRL_VREF]) begin
              next_r.ctrl[dse_pkg::CTRL_ODT] = 1'b0; // RL3
            end
          end
          dse_pkg::REG_CMD: begin
            if (r.state == C_IDLE) begin
              next_r.cmdr = pwdata[dse_pkg::CMD_W-1:0];
              next_r.issued = 1'b0;
              next_r.state = C_CMD;
            end
          end
          dse_pkg::REG_WDATA: next_r.wdata = pwdata[15:0];
          dse_pkg::REG_IRQ_STAT: next_r.irq_stat = r.irq_stat & ~pwdata[1:0];
          dse_pkg::REG_IRQ_MASK: next_r.irq_mask = pwdata[1:0];
          default: next_r.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          dse_pkg::REG_CTRL: next_r.prdata = {23'h000000, r.ctrl};
          dse_pkg::REG_CMD: next_r.prdata = {11'h000, r.cmdr};
          dse_pkg::REG_WDATA: next_r.prdata = {16'h0000, r.wdata};
          dse_pkg::REG_STATUS: next_r.prdata = {30'h00000000, r.alert_s[1], r.state != C_IDLE};
          dse_pkg::REG_IRQ_STAT: next_r.prdata = {30'h00000000, r.irq_stat};
          dse_pkg::REG_IRQ_MASK: next_r.prdata = {30'h00000000, r.irq_mask};
          default: begin
            next_r.pslverr = 1'b1;
            for (int i = 0; i < dse_pkg::RDATA_WORDS; i++) begin
              if (paddr == dse_pkg::REG_RDATA0 + 8'(4 * i)) begin
                next_r.prdata = {r.rdat[2*i+1], r.rdat[2*i]};
                next_r.pslverr = 1'b0;
              end
            end
          end
        endcase
      end
    end
    next_r.irq_stat[dse_pkg::IRQ_DONE] = next_r.irq_stat[dse_pkg::IRQ_DONE] | done_ev;
    next_r.irq_stat[dse_pkg::IRQ_ALERT] = next_r.irq_stat[dse_pkg::IRQ_ALERT] | alert_ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ctrl <= dse_pkg::CTRL_RST;
      r.cs_n <= 1'b1;
      r.cmd <= '1;
      r.dqsc <= 2'b11;
      r.dm_o <= 2'b11;
      r.alert_s <= 2'b11;
      r.alert_d <= 1'b1;
      r.dqsc_s1 <= 2'b11;
      r.dqsc_s2 <= 2'b11;
      r.dm_s1 <= 2'b11;
      r.dm_s2 <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin and bus outputs.
  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign link.ck = r.ck;
  assign link.cs_n = r.cs_n;
  assign link.cmd = r.cmd;
  assign link.par = r.par;
  assign link.ten = r.ctrl[dse_pkg::CTRL_TEN]; // RL15
  assign link.odt = r.ctrl[dse_pkg::CTRL_ODT];
  assign link.mode = dse_pkg::dse_mode_t'(r.ctrl[5:0]);
  assign link.dq_c_o = r.dq_o;
  assign link.dq_c_oe = r.dq_oe;
  assign link.dqst_c_o = r.dqst;
  assign link.dqsc_c_o = r.dqsc;
  assign link.dqs_c_oe = r.dqs_oe;
  assign link.dm_c_o = r.dm_o;
  assign link.dm_c_oe = r.dm_oe;
  assign link.alert_c_o = 1'b1;
  assign link.alert_c_oe = 1'b0;
endmodule : dse_ctrl

// >>> test/dse_link_props.sv
// Purpose: Pin checks on the link between the two ends.
// Assumes: Sampled on pclk, reset by presetn.
// Notes: Sees only link signals.
`timescale 1ns/1ps
module dse_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic odt,
  input wire logic ten,
  input wire dse_pkg::dse_mode_t mode,
  input wire logic [15:0] dq_c_o,
  input wire logic [15:0] dq_c_oe,
  input wire logic [1:0] dqst_c_o,
  input wire logic [1:0] dqsc_c_o,
  input wire logic [1:0] dqs_c_oe,
  input wire logic alert,
  input wire logic alert_d_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dqs_diff: assert property ((dqs_c_oe & ~(dqst_c_o ^ dqsc_c_o)) == 2'b00)
    else $error("strobe pair not differential");
  a_strobe_centre: assert property (dqs_c_oe[0] && $past(dqs_c_oe[0]) &&
    $changed(dqst_c_o[0]) |-> $stable(dq_c_o)) else $error("strobe edge on data change");
  a_lane_low: assert property (dqs_c_oe[0] |-> dq_c_oe[7:0] == 8'hff)
    else $error("lower strobe without low byte");
  a_cmd_hold: assert property ($fell(cs_n) |-> !cs_n [*8] ##1 cs_n)
    else $error("command not held one link period");
  a_vref_odt: assert property (mode.vref_mon |-> !odt)
    else $error("termination on during monitor");
  a_tdqs_off: assert property (!mode.tdqs_en)
    else $error("termination strobe enabled");
  a_ten_alert: assert property (ten && $past(ten, 4) |-> !alert_d_oe)
    else $error("alert driven in test mode");
  a_alert_min: assert property ($fell(alert) |=> !alert [*8])
    else $error("alert pulse too short");
endmodule : dse_link_props

// >>> test/tb.sv
// Purpose: Bench for controller and device joined by the link.
// Assumes: Controller driven over APB; checks also read device outputs and link pins.
// Notes: Ends with the verdict from conclude.
`timescale 1ns/1ps
module tb;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic vref_level = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irq, err, crc_err, par_err, ten_active, alert_in, prev_s;
  logic [15:0] first_word;
  int num_errors = 0;
  int comparisons = 0;
  int crc_n = 0;
  int par_n = 0;
  int low_n = 0;
  int tgl_n = 0;
  always #50 pclk = ~pclk;
  dse_link_if link();
  dse_ctrl i_dse_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq), .link(link.ctl));
  dse_device i_dse_device (.pclk(pclk), .presetn(presetn), .link(link.dev),
    .vref_level(vref_level), .crc_err(crc_err), .par_err(par_err), .ten_active(ten_active),
    .alert_in(alert_in), .tdqs_term(), .first_word(first_word));
  dse_link_props i_dse_link_props (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .odt(link.odt), .ten(link.ten), .mode(link.mode), .dq_c_o(link.dq_c_o),
    .dq_c_oe(link.dq_c_oe), .dqst_c_o(link.dqst_c_o), .dqsc_c_o(link.dqsc_c_o),
    .dqs_c_oe(link.dqs_c_oe), .alert(link.alert), .alert_d_oe(link.alert_d_oe));
  always @(posedge pclk) begin
    crc_n <= crc_n + int'(crc_err === 1'b1);
    par_n <= par_n + int'(par_err === 1'b1);
    low_n <= low_n + int'(link.alert === 1'b0);
    tgl_n <= tgl_n + int'(link.dqs_c_oe[0] === 1'b1 && link.dqst_c_o[0] !== prev_s);
    prev_s <= link.dqst_c_o[0];
  end
  task automatic conclude;
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(0, "bus timeout");
    if (n >= 20) conclude;
  endtask : apb
  task automatic wait_irq;
    int n;
    for (n = 0; irq !== 1'b1 && n < 3000; n++) @(posedge pclk);
    if (n >= 3000) chk(0, "irq timeout");
    if (n >= 3000) conclude;
  endtask : wait_irq
  task automatic t_write;
    int t0;
    t0 = tgl_n;
    apb(0, dse_pkg::REG_CTRL, 32'h0);
    chk(rd === 32'h0 && err === 1'b0, "ctrl reset value");
    apb(0, 8'hfc, 32'h0);
    chk(rd === 32'h0 && err === 1'b1, "unmapped read");
    apb(1, dse_pkg::REG_IRQ_MASK, 32'h3);
    apb(1, dse_pkg::REG_CTRL, 32'h23);
    apb(1, dse_pkg::REG_WDATA, 32'hfff0);
    apb(1, dse_pkg::REG_CMD, 32'h0010_0000);
    wait_irq;
    apb(1, dse_pkg::REG_IRQ_STAT, 32'h3);
    chk(first_word === 16'hfff0, "stored beat");
    chk(tgl_n - t0 == 9, "strobe edges with crc beat");
    chk(crc_n == 0 && low_n == 0, "alert without error");
  endtask : t_write
  task automatic t_read;
    apb(1, dse_pkg::REG_CMD, 32'h0);
    wait_irq;
    apb(1, dse_pkg::REG_IRQ_STAT, 32'h3);
    for (int i = 0; i < 4; i++) begin
      apb(0, dse_pkg::REG_RDATA0 + 8'(4 * i), 32'h0);
      chk(rd === {16'(16'hfff1 + 2 * i), 16'(16'hfff0 + 2 * i)}, "read word");
    end
  endtask : t_read
  task automatic t_parity;
    apb(1, dse_pkg::REG_CTRL, 32'h101);
    apb(1, dse_pkg::REG_CMD, 32'h0010_0000);
    wait_irq;
    repeat (30) @(posedge pclk);
    chk(crc_n == 1 && low_n == dse_pkg::CRC_ALERT_CYC, "crc alert");
    apb(1, dse_pkg::REG_IRQ_STAT, 32'h3);
    apb(1, dse_pkg::REG_CTRL, 32'h102);
    apb(1, dse_pkg::REG_CMD, 32'h0010_0000);
    wait_irq;
    repeat (dse_pkg::PAR_ALERT_CYC + 20) @(posedge pclk);
    apb(0, dse_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[1] === 1'b1 && par_n == 1, "parity error seen");
    chk(low_n == dse_pkg::PAR_ALERT_CYC + dse_pkg::CRC_ALERT_CYC, "parity alert");
    apb(1, dse_pkg::REG_IRQ_STAT, 32'h3);
  endtask : t_parity
  task automatic t_vref;
    apb(1, dse_pkg::REG_CTRL, 32'h44);
    apb(0, dse_pkg::REG_CTRL, 32'h0);
    chk(rd[6] === 1'b0, "odt left on");
    for (int v = 0; v < 2; v++) begin
      vref_level <= v[0];
      repeat (6) @(posedge pclk);
      chk(link.dq[0] === v[0], "reference level");
    end
  endtask : t_vref
  task automatic t_ten;
    apb(1, dse_pkg::REG_CTRL, 32'h80);
    repeat (6) @(posedge pclk);
    chk(ten_active === 1'b1 && alert_in === 1'b1, "test mode");
    apb(1, dse_pkg::REG_CTRL, 32'h0);
  endtask : t_ten
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_write;
    t_read;
    t_parity;
    t_vref;
    t_ten;
    conclude;
  end
endmodule : tb
